// ===== logic/kpc_keypad_scan.v
// keypad scan controller: direct keys, two rotary encoders, 8x8 matrix scanner
// assumes pin inputs are asynchronous and configuration ports are on clk
`timescale 1ns/1ps
`include "kpc_regs.vh"

module kpc_keypad_scan #(
    parameter TICK_CYCLES = `KPC_TICK_CYCLES
) (
    input  wire        clk,
    input  wire        rst_n,
    input  wire [7:0]  direct_key_in,
    input  wire [7:0]  matrix_row_in,
    output reg  [7:0]  matrix_col_out,
    input  wire [7:0]  debounce_interval,
    input  wire [2:0]  direct_key_count,
    input  wire        direct_enable,
    input  wire        matrix_enable,
    input  wire        encoder0_enable,
    input  wire        encoder1_enable,
    input  wire        auto_scan_mode,
    input  wire        auto_scan_trigger,
    input  wire        scan_on_activity_enable,
    input  wire [7:0]  manual_col_value,
    input  wire        status_clear,
    output reg  [7:0]  direct_keys,
    output reg  [7:0]  encoder0_count,
    output reg  [7:0]  encoder1_count,
    output reg  [63:0] matrix_keys,
    output reg         scan_busy,
    output reg         direct_activity,
    output reg         encoder_activity,
    output reg         matrix_activity
);

    // ****************************************************************
    // input synchronisers
    // ****************************************************************
    reg [7:0] dk_s1_q;
    reg [7:0] dk_s2_q;
    reg [7:0] mr_s1_q;
    reg [7:0] mr_s2_q;

    // two stages so no logic ever sees a metastable pin
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dk_s1_q <= 8'h00;
            dk_s2_q <= 8'h00;
            mr_s1_q <= 8'h00;
            mr_s2_q <= 8'h00;
        end
        else
        begin
            dk_s1_q <= direct_key_in;
            dk_s2_q <= dk_s1_q;
            mr_s1_q <= matrix_row_in;
            mr_s2_q <= mr_s1_q;
        end
    end

    // ****************************************************************
    // debounce tick divider
    // ****************************************************************
    reg [31:0] tick_cnt_q;
    wire       tick;

    assign tick = (tick_cnt_q == TICK_CYCLES - 1);

    // one enable pulse per debounce time unit
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            tick_cnt_q <= 32'h0000_0000;
        else if (tick)
            tick_cnt_q <= 32'h0000_0000;
        else
            tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
    end

    // ****************************************************************
    // direct key debounce and masking
    // ****************************************************************
    reg  [7:0] dk_last_q;
    reg  [7:0] dk_deb_cnt_q;
    reg  [7:0] dk_stable_q;
    wire [7:0] dk_count_mask;
    wire [7:0] dk_key_mask;
    wire [7:0] dk_clean;

    // inputs enabled contiguously from 0; 111 selects all eight
    assign dk_count_mask = (direct_key_count == `KPC_DKN_ALL) ? 8'hFF :
                           ((8'h01 << (direct_key_count + 3'h1)) - 8'h01);
    // encoder pairs are taken away from the key view, 7..4 never are
    assign dk_key_mask = dk_count_mask & {4'hF,
                                          {2{~encoder1_enable}},
                                          {2{~encoder0_enable}}};
    // zero interval passes the synchronised level straight through
    assign dk_clean = (debounce_interval == 8'h00) ? dk_s2_q : dk_stable_q;

    // a level must hold a whole interval before it is accepted
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dk_last_q    <= 8'h00;
            dk_deb_cnt_q <= `KPC_DEB_RST;
            dk_stable_q  <= 8'h00;
        end
        else
        begin
            dk_last_q <= dk_s2_q;
            if (dk_s2_q != dk_last_q)
                dk_deb_cnt_q <= 8'h00;
            else if (tick && dk_deb_cnt_q != debounce_interval)
                dk_deb_cnt_q <= dk_deb_cnt_q + 8'h01;
            else if (dk_deb_cnt_q == debounce_interval)
                dk_stable_q <= dk_s2_q;
        end
    end

    // ****************************************************************
    // rotary encoders
    // ****************************************************************
    reg [1:0] enc0_prev_q;
    reg [1:0] enc1_prev_q;
    wire      enc0_step;
    wire      enc1_step;
    wire      enc0_up;
    wire      enc1_up;

    // quadrature: one step per change, direction from prev[1]^cur[0]
    assign enc0_step = encoder0_enable && (dk_clean[1:0] != enc0_prev_q);
    assign enc1_step = encoder1_enable && (dk_clean[3:2] != enc1_prev_q);
    assign enc0_up   = enc0_prev_q[1] ^ dk_clean[0];
    assign enc1_up   = enc1_prev_q[1] ^ dk_clean[2];

    // counters wrap; software reads the difference between samples
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            enc0_prev_q    <= 2'h0;
            enc1_prev_q    <= 2'h0;
            encoder0_count <= 8'h00;
            encoder1_count <= 8'h00;
        end
        else
        begin
            enc0_prev_q <= dk_clean[1:0];
            enc1_prev_q <= dk_clean[3:2];
            if (enc0_step)
                encoder0_count <= enc0_up ? encoder0_count + 8'h01 : encoder0_count - 8'h01;
            if (enc1_step)
                encoder1_count <= enc1_up ? encoder1_count + 8'h01 : encoder1_count - 8'h01;
        end
    end

    // ****************************************************************
    // matrix activity debounce
    // ****************************************************************
    reg  [7:0] mr_last_q;
    reg  [7:0] mr_deb_cnt_q;
    reg        act_fired_q;
    wire       rows_active;
    wire       act_stable;

    function dk_deb_ok;
        input [7:0] cnt;
        input [7:0] ivl;
        begin
            dk_deb_ok = (cnt == ivl);
        end
    endfunction

    assign rows_active = |mr_s2_q;
    assign act_stable  = rows_active && !act_fired_q && (mr_s2_q == mr_last_q) &&
                         (dk_deb_ok(mr_deb_cnt_q, debounce_interval));

    // activity must be stable one full interval; fires once until the rows next read all low
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mr_last_q    <= 8'h00;
            mr_deb_cnt_q <= `KPC_DEB_RST;
            act_fired_q  <= 1'b0;
        end
        else
        begin
            mr_last_q <= mr_s2_q;
            if (mr_s2_q != mr_last_q)
                mr_deb_cnt_q <= 8'h00;
            else if (tick && mr_deb_cnt_q != debounce_interval)
                mr_deb_cnt_q <= mr_deb_cnt_q + 8'h01;
            if (!rows_active)
                act_fired_q <= 1'b0;
            else if (act_stable)
                act_fired_q <= 1'b1;
        end
    end

    // ****************************************************************
    // matrix scanner
    // ****************************************************************
    reg [1:0]  st_q;
    reg [2:0]  col_q;
    reg [3:0]  settle_q;
    reg [63:0] scan_img_q;
    wire       scan_start;

    // trigger or stable activity starts a sweep in auto mode only
    assign scan_start = matrix_enable && auto_scan_mode &&
                        (auto_scan_trigger ||
                         (scan_on_activity_enable && act_stable));

    // one column high at a time during a sweep; rows settle before being read
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q           <= `KPC_ST_IDLE;
            col_q          <= 3'h0;
            settle_q       <= 4'h0;
            scan_img_q     <= 64'h0;
            matrix_keys    <= 64'h0;
            matrix_col_out <= `KPC_COLS_RST;
            scan_busy      <= 1'b0;
        end
        else
        begin
            case (st_q)
                `KPC_ST_IDLE:
                begin
                    scan_busy <= 1'b0;
                    if (!auto_scan_mode)
                        matrix_col_out <= matrix_enable ? manual_col_value : 8'h00;
                    else if (matrix_enable && scan_on_activity_enable)
                        matrix_col_out <= 8'hFF; // all columns up so any press reaches the rows
                    else
                        matrix_col_out <= 8'h00;
                    if (scan_start)
                    begin
                        matrix_col_out <= 8'h00;
                        st_q      <= `KPC_ST_DRIVE;
                        col_q     <= 3'h0;
                        scan_busy <= 1'b1;
                    end
                end
                `KPC_ST_DRIVE:
                begin
                    matrix_col_out <= 8'h01 << col_q;
                    settle_q       <= `KPC_SETTLE_CYCLES;
                    st_q           <= `KPC_ST_SAMPLE;
                end
                `KPC_ST_SAMPLE:
                begin
                    if (settle_q != 4'h0)
                        settle_q <= settle_q - 4'h1;
                    else
                    begin
                        scan_img_q[{col_q, 3'h0} +: 8] <= mr_s2_q;
                        if (col_q == 3'h7)
                        begin
                            matrix_keys <= {mr_s2_q, scan_img_q[55:0]};
                            st_q        <= `KPC_ST_IDLE;
                        end
                        else
                        begin
                            col_q <= col_q + 3'h1;
                            st_q  <= `KPC_ST_DRIVE;
                        end
                    end
                end
                default:
                    st_q <= `KPC_ST_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // direct key view and status flags
    // ****************************************************************
    // flags are sticky; a new event in the clear cycle wins
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            direct_keys      <= 8'h00;
            direct_activity  <= 1'b0;
            encoder_activity <= 1'b0;
            matrix_activity  <= 1'b0;
        end
        else
        begin
            direct_keys <= direct_enable ? (dk_clean & dk_key_mask) : 8'h00;
            if (direct_enable && ((dk_clean & dk_key_mask) != direct_keys))
                direct_activity <= 1'b1;
            else if (status_clear)
                direct_activity <= 1'b0;
            if (enc0_step || enc1_step)
                encoder_activity <= 1'b1;
            else if (status_clear)
                encoder_activity <= 1'b0;
            if ((matrix_enable && act_stable) ||
                (st_q == `KPC_ST_SAMPLE && settle_q == 4'h0 && col_q == 3'h7))
                matrix_activity <= 1'b1;
            else if (status_clear)
                matrix_activity <= 1'b0;
        end
    end

endmodule // kpc_keypad_scan

// ===== logic/kpc_regs.vh
// constants for the keypad scan controller: timing, field layouts, reset values
// assumes the includer uses them on a 100 MHz clock
`ifndef KPC_REGS_VH
`define KPC_REGS_VH
`define KPC_CLK_PERIOD_NS   10
`define KPC_TICK_NS         100000
`define KPC_TICK_CYCLES     (`KPC_TICK_NS / `KPC_CLK_PERIOD_NS)
`define KPC_DEB_RST         8'h00
`define KPC_COLS_RST        8'h00
`define KPC_DKN_ALL         3'h7
`define KPC_ST_IDLE         2'h0
`define KPC_ST_DRIVE        2'h1
`define KPC_ST_SAMPLE       2'h2
`define KPC_SETTLE_CYCLES   4'h8
`endif

// ===== test/kpc_keypad_scan_properties.sv
// port checker for the keypad scan controller
// assumes the bind below attaches it to every instance of the top module
`timescale 1ns/1ps
module kpc_keypad_scan_properties (
    input wire        clk,
    input wire        rst_n,
    input wire [7:0]  direct_key_in,
    input wire [7:0]  matrix_col_out,
    input wire [7:0]  debounce_interval,
    input wire [2:0]  direct_key_count,
    input wire        direct_enable,
    input wire        matrix_enable,
    input wire        encoder0_enable,
    input wire        encoder1_enable,
    input wire        auto_scan_mode,
    input wire        auto_scan_trigger,
    input wire [7:0]  manual_col_value,
    input wire [7:0]  direct_keys,
    input wire [63:0] matrix_keys,
    input wire        scan_busy
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // first column must hold through its whole settle time
    sequence col0_hold_s;
        (matrix_col_out == 8'h01) [*8];
    endsequence
    manual_cols_a:
    assert property (matrix_enable && !auto_scan_mode && !scan_busy |=> matrix_col_out == $past(manual_col_value))
        else $error("manual column value not driven");
    one_column_a:
    assert property (scan_busy && $past(scan_busy) |-> $onehot0(matrix_col_out)) else $error("several columns driven");
    trig_start_a:
    assert property (auto_scan_mode && matrix_enable && auto_scan_trigger && !scan_busy |=> scan_busy)
        else $error("trigger did not start a sweep");
    sweep_order_a:
    assert property ($rose(scan_busy) |=> col0_hold_s ##1 (matrix_col_out == 8'h01) [*2] ##1 matrix_col_out == 8'h02)
        else $error("column order or hold wrong");
    keys_update_a:
    assert property (matrix_keys != $past(matrix_keys) |-> scan_busy) else $error("scan image changed outside sweep");
    sweep_len_a:
    assert property ($rose(scan_busy) |-> ##[78:86] $fell(scan_busy)) else $error("sweep length wrong");
    debounce_off_a:
    assert property ((debounce_interval == 8'h00 && direct_enable && direct_key_count == 3'h7 && !encoder0_enable
        && !encoder1_enable && $stable(direct_key_in)) [*4] |-> direct_keys == direct_key_in)
        else $error("bypassed keys do not follow pins");
    count_mask_a:
    assert property ((direct_enable && direct_key_count == 3'h0) [*4] |-> direct_keys[7:1] == 7'h00)
        else $error("keys above count not masked");
endmodule // kpc_keypad_scan_properties

bind kpc_keypad_scan kpc_keypad_scan_properties u_kpc_keypad_scan_properties (.*);

// ===== test/kpc_keypad_model.sv
// switches, one quadrature encoder and a matrix keypad with row pull-downs
// assumes the bench steps the encoder one clock at a time
`timescale 1ns/1ps
module kpc_keypad_model (
    input  wire        clk,
    input  wire [63:0] pressed,
    input  wire [7:0]  matrix_col_out,
    input  wire [5:0]  key_sw,
    input  wire        enc_step,
    output wire [7:0]  direct_key_in,
    output wire [7:0]  matrix_row_in
);
    reg [1:0] phase_q = 2'h0;
    reg [7:0] rows;
    integer   c;
    // rows stay pulled low unless a driven column meets a closed key
    always @*
    begin
        rows = 8'h00;
        for (c = 0; c < 8; c = c + 1)
            if (matrix_col_out[c])
                rows = rows | pressed[c*8 +: 8];
    end
    assign matrix_row_in = rows;
    // gray sequence 00,01,11,10 per step, so the pair never skips a state
    always @(posedge clk)
        if (enc_step)
            phase_q <= phase_q + 2'h1;
    assign direct_key_in = {key_sw, phase_q[1], phase_q[1] ^ phase_q[0]};
endmodule // kpc_keypad_model

// ===== test/kpc_keypad_scan_bench.sv
// self-checking bench for the keypad scan controller
// assumes a short tick of 4 clocks so debounce waits stay brief
`timescale 1ns/1ps
module kpc_keypad_scan_bench;
    reg clk = 1'b0, rst_n = 1'b0, direct_enable = 1'b1, matrix_enable = 1'b1, encoder0_enable = 1'b0;
    reg encoder1_enable = 1'b0, auto_scan_mode = 1'b0, auto_scan_trigger = 1'b0, scan_on_activity_enable = 1'b0;
    reg status_clear = 1'b0, enc_step = 1'b0;
    reg [7:0] debounce_interval = 8'h00, manual_col_value = 8'h00;
    reg [2:0] direct_key_count = 3'h7;
    reg [5:0] key_sw = 6'h29;
    reg [63:0] pressed = 64'h0;
    wire [7:0] direct_key_in, matrix_row_in, matrix_col_out, direct_keys, encoder0_count, encoder1_count;
    wire [63:0] matrix_keys;
    wire scan_busy, direct_activity, encoder_activity, matrix_activity;
    integer errors = 0, compares = 0, i;
    kpc_keypad_scan #(.TICK_CYCLES(4)) u_kpc_keypad_scan (.*);
    kpc_keypad_model u_kpc_keypad_model (.*);
    always #5 clk = ~clk;
    // ****************
    // helpers
    // ****************
    task check(input [63:0] got, input [63:0] exp);
    begin
        compares = compares + 1;
        if (got !== exp)
        begin
            errors = errors + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask
    task tick(input integer n);
        repeat (n) @(posedge clk);
    endtask
    // bounded wait, so a dead sweep shows up as a mismatch
    task wait_busy(input v);
    begin
        for (i = 0; i < 200 && scan_busy !== v; i = i + 1)
            @(posedge clk);
        check(scan_busy, v);
    end
    endtask
    task print_verdict;
    begin
        $display("compares=%0d errors=%0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    end
    endtask
    initial
    begin
        #20000;
        errors = errors + 1;
        print_verdict;
    end
    // tests run as one sequence; direct and matrix sections share the run
    initial
    begin
        tick(2);
        rst_n <= 1'b1;
        manual_col_value <= 8'h5A;
        tick(3);
        check(matrix_col_out, 8'h5A);
        auto_scan_trigger <= 1'b1;
        tick(3);
        check(scan_busy, 1'b0);
        auto_scan_trigger <= 1'b0;
        manual_col_value <= 8'h00;
        check(direct_keys, 8'hA4);
        direct_key_count <= 3'h3;
        tick(5);
        check(direct_keys, 8'h04);
        direct_key_count <= 3'h0;
        tick(5);
        check(direct_keys, 8'h00);
        direct_key_count <= 3'h7;
        encoder0_enable <= 1'b1;
        encoder1_enable <= 1'b1;
        tick(5);
        check(direct_keys, 8'hA0);
        key_sw <= 6'h2B;
        repeat (3)
        begin
            enc_step <= 1'b1;
            tick(1);
            enc_step <= 1'b0;
            tick(5);
        end
        check(encoder0_count, 8'h03);
        check(encoder1_count, 8'h01);
        check(encoder_activity, 1'b1);
        encoder0_enable <= 1'b0;
        encoder1_enable <= 1'b0;
        tick(6);
        debounce_interval <= 8'h02;
        key_sw <= 6'h3F;
        status_clear <= 1'b1;
        tick(1);
        status_clear <= 1'b0;
        tick(4);
        check(direct_keys, 8'hAE);
        check(encoder_activity, 1'b0);
        check(direct_activity, 1'b0);
        tick(20);
        check(direct_keys, 8'hFE);
        check(direct_activity, 1'b1);
        debounce_interval <= 8'h00;
        auto_scan_mode <= 1'b1;
        pressed <= 64'h0100_0000_0020_0000;
        auto_scan_trigger <= 1'b1;
        tick(1);
        auto_scan_trigger <= 1'b0;
        wait_busy(1'b1);
        wait_busy(1'b0);
        check(matrix_keys, 64'h0100_0000_0020_0000);
        check(matrix_activity, 1'b1);
        // a held key alone must start the next sweep
        pressed <= 64'h0000_0000_0000_8000;
        scan_on_activity_enable <= 1'b1;
        wait_busy(1'b1);
        wait_busy(1'b0);
        check(matrix_keys, 64'h0000_0000_0000_8000);
        print_verdict;
    end
endmodule // kpc_keypad_scan_bench
